// >>> src/tttv_pkg.sv
// Purpose: shared constants and carriers for the turbine trip channel vote
// Assumes: power is unsigned fixed point in hundredths of percent rated power
// Notes: one channel of four; peers and contacts arrive as plain levels
package tttv_pkg;
    // power scale: 1 lsb = 0.01 percent rated thermal power
    localparam int PWR_W = 14;
    localparam logic [PWR_W-1:0] PWR_MAX = 14'h30d4; // 125.00 percent
    localparam logic [PWR_W-1:0] ENABLE_SP_RST = 14'h0b9f; // 29.75 percent
    localparam logic [PWR_W-1:0] RESET_SP_RST = 14'h0ad7; // 27.75 percent
    localparam int CHAN_N = 4;
    localparam logic [2:0] VOTE_MIN = 3'h2; // two of four
    // maintenance parameter selectors
    localparam logic [1:0] PSEL_ENABLE = 2'h0;
    localparam logic [1:0] PSEL_RESET = 2'h1;
    // processing response bound
    localparam int RESP_TIME_MS = 500;
    localparam int CLK_HZ = 10000000;
    localparam int RESP_CYCLES = RESP_TIME_MS * (CLK_HZ / 1000);
    // latency of this logic from power input to channel trip, in cycles
    localparam int PWR_LAT = 3;

    // power values of the four channels, index 0 is this channel
    typedef struct packed {
        logic [PWR_W-1:0] p3;
        logic [PWR_W-1:0] p2;
        logic [PWR_W-1:0] p1;
        logic [PWR_W-1:0] p0;
    } tttv_power_type;

    // maintenance write request
    typedef struct packed {
        logic wrEn;
        logic [1:0] sel;
        logic [PWR_W-1:0] data;
    } tttv_param_wr_type;

    // count of set bits in a group of four
    function automatic logic [2:0] tttvCount4(input logic [3:0] v);
        tttvCount4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} +
            {2'h0, v[3]};
    endfunction
endpackage

// >>> src/tttv_second_max.sv
// Purpose: registered second-highest of four power values
// Assumes: inputs already clamped to range
// Notes: ties count separately, so two equal maxima give that value
`timescale 1ns/1ps
`default_nettype none
module tttv_second_max
    import tttv_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire tttv_power_type powerIn,
    output var logic [PWR_W-1:0] secondMax_q
);
    wire logic [PWR_W-1:0] hiA, loA, hiB, loB, topLo, restHi, secondMax_d;

    // pairwise sort then pick the larger of the losers' best and top loser
    assign hiA = (powerIn.p0 >= powerIn.p1) ? powerIn.p0 : powerIn.p1;
    assign loA = (powerIn.p0 >= powerIn.p1) ? powerIn.p1 : powerIn.p0;
    assign hiB = (powerIn.p2 >= powerIn.p3) ? powerIn.p2 : powerIn.p3;
    assign loB = (powerIn.p2 >= powerIn.p3) ? powerIn.p3 : powerIn.p2;
    assign topLo = (hiA >= hiB) ? hiB : hiA;
    assign restHi = (hiA >= hiB) ? loA : loB;
    assign secondMax_d = (topLo >= restHi) ? topLo : restHi;

    // register cuts the comparator path from the sort tree
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            secondMax_q <= '0;
        end else begin
            secondMax_q <= secondMax_d;
        end
    end
endmodule
`default_nettype wire

// >>> src/tttv_channel.sv
// Purpose: one channel of the anticipatory trip on main turbine trip
// Assumes: all inputs synchronous to core_clk; own contact high means closed, peer contact high means open
// Notes: annunciator and reactor trip outputs are all registered
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - select the second-highest of the four channel power values.
// - set trip enable when that value reaches the enable setpoint.
// - clear trip enable when that value is at or below the reset value.
// - trip the channel while enabled and two or more contacts are open.
// - read one contact here and share its state with the three peers.
// - reactor trip when two or more channel trips are present.
// - reactor trip stays latched until the operator resets it.
// - alert annunciator whenever any contact is open, bypass or not.
// - bypass annunciator whenever trip enable is clear.
// - a manually bypassed channel drops out of the channel trip vote.
// - shutdown bypass has no path into this function.
// - enable and reset setpoints live in maintenance-writable storage.
// - power values are held in the range 0 to 125 percent.
// - input change to trip output well within 500 ms.
// - an open contact means turbine tripped.
module tttv_channel
    import tttv_pkg::*;
#(
    parameter int RESP_LIMIT = RESP_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire tttv_power_type powerIn,
    input wire logic ownContactClosed,
    input wire logic [2:0] peerContactOpen,
    input wire logic [2:0] peerChanTrip,
    input wire logic [3:0] chanManualBypass,
    input wire logic operatorReset,
    input wire tttv_param_wr_type paramWr,
    output var logic ownContactOpen_q,
    output var logic chanTrip_q,
    output var logic reactorTrip_q,
    output var logic alertAnn_q,
    output var logic bypassAnn_q,
    output var logic tripEnable_q,
    output var logic [PWR_W-1:0] enableSp_q,
    output var logic [PWR_W-1:0] resetSp_q
);
    // refuse a response bound that this pipeline could never meet
    if (RESP_LIMIT < PWR_LAT + 1) begin : gBadLimit
        $error("RESP_LIMIT too small for the processing latency");
    end

    wire tttv_power_type powerClamp;
    wire logic [PWR_W-1:0] secondMax;
    wire logic [3:0] contactOpen;
    wire logic [2:0] openCount;
    wire logic [3:0] votingTrips;
    wire logic [2:0] tripCount;
    wire logic enableSet, enableClr, tripEnable_d, chanTrip_d;
    wire logic voteTrip, reactorTrip_d, paramOk;

    // clamp each power value to the top of the range
    function automatic logic [PWR_W-1:0] clampPwr(input logic [PWR_W-1:0] v);
        clampPwr = (v > PWR_MAX) ? PWR_MAX : v;
    endfunction

    // which of the four values stand at or above a level
    function automatic logic [3:0] geMask(input tttv_power_type p,
        input logic [PWR_W-1:0] v);
        geMask = {p.p3 >= v, p.p2 >= v, p.p1 >= v, p.p0 >= v};
    endfunction

    // which of the four values stand at or below a level
    function automatic logic [3:0] leMask(input tttv_power_type p,
        input logic [PWR_W-1:0] v);
        leMask = {p.p3 <= v, p.p2 <= v, p.p1 <= v, p.p0 <= v};
    endfunction

    // out-of-range inputs pinned to 125 percent so a bad value still trips
    assign powerClamp.p0 = clampPwr(powerIn.p0);
    assign powerClamp.p1 = clampPwr(powerIn.p1);
    assign powerClamp.p2 = clampPwr(powerIn.p2);
    assign powerClamp.p3 = clampPwr(powerIn.p3);

    tttv_second_max uSecondMax (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .powerIn(powerClamp),
        .secondMax_q(secondMax)
    );

    // comparator with hysteresis; reset threshold wins if they overlap
    assign enableSet = secondMax >= enableSp_q;
    assign enableClr = secondMax <= resetSp_q;
    // shutdown bypass is deliberately not an input here
    assign tripEnable_d = enableClr ? 1'b0 :
        (enableSet ? 1'b1 : tripEnable_q);

    // contacts open on loss of pressure, so open counts as tripped
    assign contactOpen = {peerContactOpen, ~ownContactClosed};
    assign openCount = tttvCount4(contactOpen);
    assign chanTrip_d = tripEnable_q && (openCount >= VOTE_MIN);

    // bypassed channels removed, leaving two of the remaining three
    assign votingTrips = {peerChanTrip, chanTrip_q} & ~chanManualBypass;
    assign tripCount = tttvCount4(votingTrips);
    assign voteTrip = tripCount >= VOTE_MIN;
    // a new vote beats a reset in the same cycle
    assign reactorTrip_d = voteTrip ||
        (reactorTrip_q && !operatorReset);

    // screen already checks range; this guards a stray write as well
    assign paramOk = paramWr.data <= PWR_MAX;

    // maintenance-writable thresholds
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            enableSp_q <= ENABLE_SP_RST;
            resetSp_q <= RESET_SP_RST;
        end else if (paramWr.wrEn && paramOk) begin
            if (paramWr.sel == PSEL_ENABLE) begin
                enableSp_q <= paramWr.data;
            end
            if (paramWr.sel == PSEL_RESET) begin
                resetSp_q <= paramWr.data;
            end
        end
    end

    // trip enable and channel trip
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tripEnable_q <= 1'b0;
            chanTrip_q <= 1'b0;
        end else begin
            tripEnable_q <= tripEnable_d;
            chanTrip_q <= chanTrip_d;
        end
    end

    // cycles a trip demand has waited for the channel trip; a stuck
    // demand would show here long before the response bound
    localparam int RESP_W = $clog2(RESP_LIMIT + 1);
    logic [RESP_W-1:0] respWait_q;
    wire logic [RESP_W-1:0] respWait_d;
    assign respWait_d = (chanTrip_d && !chanTrip_q) ?
        respWait_q + 1'b1 : '0;

    // response watch counter
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            respWait_q <= '0;
        end else begin
            respWait_q <= respWait_d;
        end
    end

    // shared contact state, annunciators and reactor trip latch
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ownContactOpen_q <= 1'b0;
            alertAnn_q <= 1'b0;
            bypassAnn_q <= 1'b1;
            reactorTrip_q <= 1'b0;
        end else begin
            ownContactOpen_q <= ~ownContactClosed;
            alertAnn_q <= |contactOpen;
            bypassAnn_q <= ~tripEnable_d;
            reactorTrip_q <= reactorTrip_d;
        end
    end

    // checks: each watches design state against the rule it names
    chk_second_max_pick: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        tttvCount4(geMask($past(powerClamp), secondMax)) >= 3'h2 &&
            tttvCount4(leMask($past(powerClamp), secondMax)) >= 3'h3)
        else $error("second max is not the second-highest power");

    chk_second_max_range: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        secondMax <= PWR_MAX)
        else $error("selected power above range");

    chk_enable_rise: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (enableSet && !enableClr) |=> tripEnable_q)
        else $error("enable not set at setpoint");

    chk_enable_fall: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        enableClr |=> !tripEnable_q)
        else $error("enable not cleared at reset value");

    chk_enable_hold: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (!enableSet && !enableClr) |=> $stable(tripEnable_q))
        else $error("enable moved between thresholds");

    chk_chan_trip_vote: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        chanTrip_q == $past(tripEnable_q &&
            $countones({peerContactOpen, !ownContactClosed}) >= 2))
        else $error("channel trip disagrees with enable and vote");

    chk_disabled_no_trip: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        !tripEnable_q |=> !chanTrip_q)
        else $error("channel trip while disabled");

    chk_contact_share: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        ownContactOpen_q == !$past(ownContactClosed))
        else $error("shared contact state wrong");

    chk_trip_latch: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (reactorTrip_q && !operatorReset) |=> reactorTrip_q)
        else $error("reactor trip dropped without reset");

    chk_trip_release: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        $fell(reactorTrip_q) |-> $past(operatorReset))
        else $error("reactor trip cleared with no operator reset");

    chk_vote_trip: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (tripCount >= VOTE_MIN) |=> reactorTrip_q)
        else $error("reactor trip missed on two channel trips");

    chk_trip_cause: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        $rose(reactorTrip_q) |-> $past($countones({peerChanTrip,
            chanTrip_q} & ~chanManualBypass) >= 2))
        else $error("reactor trip without two voting channels");

    chk_bypass_mask: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (chanManualBypass[0] && !reactorTrip_q &&
            $countones(peerChanTrip & ~chanManualBypass[3:1]) < 2)
        |=> !reactorTrip_q)
        else $error("bypassed channel still counted in the vote");

    chk_alert_any: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (|contactOpen) |=> alertAnn_q)
        else $error("alert missing with an open contact");

    chk_alert_clear: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        !(|contactOpen) |=> !alertAnn_q)
        else $error("alert raised with all contacts closed");

    chk_bypass_ann: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        ##1 (bypassAnn_q == !tripEnable_q))
        else $error("bypass annunciator disagrees with enable");

    chk_bypass_low: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (secondMax <= resetSp_q) |=> bypassAnn_q)
        else $error("bypass annunciator missing at low power");

    chk_bypass_high: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (secondMax >= enableSp_q && secondMax > resetSp_q) |=>
            !bypassAnn_q)
        else $error("bypass annunciator on above the setpoint");

    chk_response_time: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (tripEnable_q && openCount >= VOTE_MIN) ##1
            (peerChanTrip[0] && !chanManualBypass[0] &&
            !chanManualBypass[1]) |=> reactorTrip_q)
        else $error("trip response too slow");

    chk_response_bound: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        respWait_q < RESP_LIMIT)
        else $error("channel trip demand waited past the bound");

    chk_param_range: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        enableSp_q <= PWR_MAX && resetSp_q <= PWR_MAX)
        else $error("setpoint out of range");

    chk_param_write_en: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (paramWr.wrEn && paramWr.sel == PSEL_ENABLE && paramOk) |=>
            enableSp_q == $past(paramWr.data))
        else $error("enable setpoint write lost");

    chk_param_write_rst: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (paramWr.wrEn && paramWr.sel == PSEL_RESET && paramOk) |=>
            resetSp_q == $past(paramWr.data))
        else $error("reset value write lost");

    chk_param_refuse: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (paramWr.wrEn && paramWr.data > PWR_MAX) |=>
            ($stable(enableSp_q) && $stable(resetSp_q)))
        else $error("out-of-range setpoint accepted");

    chk_param_hold: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        !paramWr.wrEn |=>
            ($stable(enableSp_q) && $stable(resetSp_q)))
        else $error("setpoint moved without a write");
endmodule
`default_nettype wire

// >>> tb/tttv_field_model.sv
// Purpose: pressure contacts and three peer channels around one channel
// Assumes: peers vote on the same four contacts as the channel under test
// Notes: slowLink delays peer contact status by one cycle
`timescale 1ns/1ps
`default_nettype none
module tttv_field_model
    import tttv_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [3:0] contactOpenCmd,
    input wire logic [2:0] peerEnable,
    input wire logic slowLink,
    input wire logic ownContactOpen_q,
    output logic ownContactClosed,
    output logic [2:0] peerContactOpen,
    output logic [2:0] peerChanTrip
);
    logic [2:0] linkDelay_q;
    logic [3:0] seenOpen;
    // contacts are held closed by pressure; open means tripped
    assign ownContactClosed = !contactOpenCmd[0];
    // link latency: a slow peer shows its contact a cycle late
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            linkDelay_q <= 3'h0;
        end else begin
            linkDelay_q <= contactOpenCmd[3:1];
        end
    end
    assign peerContactOpen = slowLink ? linkDelay_q : contactOpenCmd[3:1];
    // peers see the own contact only through the shared status
    assign seenOpen = {contactOpenCmd[3:1], ownContactOpen_q};
    // each enabled peer trips on two open contacts
    assign peerChanTrip = peerEnable & {3{tttvCount4(seenOpen) >= VOTE_MIN}};
endmodule
`default_nettype wire

// >>> tb/turbine_trip_channel_vote_tb.sv
// Purpose: self-checking bench for one turbine trip channel
// Assumes: inputs change 10 ns after the rising edge
// Notes: response bound shortened to 8 cycles
`timescale 1ns/1ps
`default_nettype none
module turbine_trip_channel_vote_tb;
    import tttv_pkg::*;
    logic core_clk, rst_b, ownContactClosed, operatorReset, slowLink;
    logic ownContactOpen_q, chanTrip_q, reactorTrip_q, alertAnn_q;
    logic bypassAnn_q, tripEnable_q;
    logic [2:0] peerContactOpen, peerChanTrip, peerEn;
    logic [3:0] chanManualBypass, contactCmd;
    logic [PWR_W-1:0] enableSp_q, resetSp_q;
    tttv_power_type powerIn;
    tttv_param_wr_type paramWr;
    int nErrors = 0;
    int samplesChecked = 0;
    tttv_channel #(.RESP_LIMIT(8)) u_dut (.core_clk(core_clk),
        .rst_b(rst_b), .powerIn(powerIn), .ownContactClosed(ownContactClosed),
        .peerContactOpen(peerContactOpen), .peerChanTrip(peerChanTrip),
        .chanManualBypass(chanManualBypass), .operatorReset(operatorReset),
        .paramWr(paramWr), .ownContactOpen_q(ownContactOpen_q),
        .chanTrip_q(chanTrip_q), .reactorTrip_q(reactorTrip_q),
        .alertAnn_q(alertAnn_q), .bypassAnn_q(bypassAnn_q),
        .tripEnable_q(tripEnable_q), .enableSp_q(enableSp_q),
        .resetSp_q(resetSp_q));
    tttv_field_model u_field (.core_clk(core_clk), .rst_b(rst_b),
        .contactOpenCmd(contactCmd), .peerEnable(peerEn), .slowLink(slowLink),
        .ownContactOpen_q(ownContactOpen_q),
        .ownContactClosed(ownContactClosed),
        .peerContactOpen(peerContactOpen), .peerChanTrip(peerChanTrip));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #10;
    endtask
    task automatic chkBit(input logic exp, input logic got);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic chkWord(input logic [13:0] exp, input logic [13:0] got);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic finishTest();
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // p0 is this channel; over-range values are expected to clamp
    task automatic setPow(input logic [13:0] a, b, c, d);
        powerIn = {d, c, b, a};
    endtask
    task automatic wr(input logic [1:0] s, input logic [13:0] v);
        paramWr = {1'b1, s, v};
        step(1);
        paramWr.wrEn = 1'b0;
        step(1);
    endtask
    task automatic testEnable();
        setPow(14'h30d4, 14'h03e8, 14'h03e8, 14'h03e8);
        step(3);
        chkBit(1'b0, tripEnable_q);
        setPow(14'h0b9e, 14'h3fff, 14'h0000, 14'h0000);
        step(3);
        chkBit(1'b0, tripEnable_q);
        setPow(14'h0b9f, 14'h3fff, 14'h0000, 14'h0000);
        step(2);
        chkBit(1'b1, tripEnable_q);
        chkBit(1'b0, bypassAnn_q);
        setPow(14'h0ad8, 14'h0ad8, 14'h0000, 14'h0000);
        step(3);
        chkBit(1'b1, tripEnable_q);
        setPow(14'h0ad7, 14'h30d4, 14'h0ad7, 14'h0000);
        step(2);
        chkBit(1'b0, tripEnable_q);
        chkBit(1'b1, bypassAnn_q);
        setPow(14'h0b00, 14'h0b00, 14'h0000, 14'h0000);
        step(3);
        chkBit(1'b0, tripEnable_q);
    endtask
    task automatic testTrip();
        setPow(14'h0c00, 14'h0c00, 14'h0000, 14'h0000);
        contactCmd = 4'h2;
        step(2);
        chkBit(1'b1, alertAnn_q);
        chkBit(1'b0, chanTrip_q);
        contactCmd = 4'h3;
        step(1);
        chkBit(1'b1, ownContactOpen_q);
        chkBit(1'b1, chanTrip_q);
        step(1);
        chkBit(1'b0, reactorTrip_q);
        setPow(14'h0000, 14'h0000, 14'h0000, 14'h0000);
        step(3);
        chkBit(1'b0, chanTrip_q);
        chkBit(1'b1, alertAnn_q);
        contactCmd = 4'h0;
        step(1);
        chkBit(1'b0, alertAnn_q);
    endtask
    task automatic testVote();
        setPow(14'h0c00, 14'h0c00, 14'h0c00, 14'h0000);
        peerEn = 3'h1;
        slowLink = 1'b1;
        step(2);
        contactCmd = 4'h3;
        for (int i = 0; i < 8 && reactorTrip_q !== 1'b1; i++) step(1);
        chkBit(1'b1, reactorTrip_q);
        if (reactorTrip_q !== 1'b1) finishTest();
        operatorReset = 1'b1;
        step(2);
        chkBit(1'b1, reactorTrip_q);
        operatorReset = 1'b0;
        contactCmd = 4'h0;
        step(4);
        chkBit(1'b1, reactorTrip_q);
        contactCmd = 4'h3;
        chanManualBypass = 4'h1;
        step(4);
        operatorReset = 1'b1;
        step(2);
        chkBit(1'b0, reactorTrip_q);
        operatorReset = 1'b0;
        chanManualBypass = 4'h0;
        contactCmd = 4'h0;
        peerEn = 3'h0;
        step(2);
    endtask
    task automatic testParams();
        setPow(14'h0000, 14'h0000, 14'h0000, 14'h0000);
        wr(PSEL_ENABLE, 14'h1388);
        chkWord(14'h1388, enableSp_q);
        wr(PSEL_RESET, 14'h1000);
        chkWord(14'h1000, resetSp_q);
        wr(PSEL_ENABLE, 14'h30d5);
        chkWord(14'h1388, enableSp_q);
        wr(2'h2, 14'h0001);
        chkWord(14'h1000, resetSp_q);
        setPow(14'h1388, 14'h1388, 14'h0000, 14'h0000);
        step(2);
        chkBit(1'b1, tripEnable_q);
        setPow(14'h1000, 14'h1000, 14'h0000, 14'h0000);
        step(2);
        chkBit(1'b0, tripEnable_q);
    endtask
    // main sequence: reset values are checked while reset is held
    initial begin
        rst_b = 1'b0;
        powerIn = '0;
        paramWr = '0;
        contactCmd = 4'h0;
        peerEn = 3'h0;
        slowLink = 1'b0;
        chanManualBypass = 4'h0;
        operatorReset = 1'b0;
        step(20);
        chkBit(1'b1, bypassAnn_q);
        chkWord(ENABLE_SP_RST, enableSp_q);
        chkWord(RESET_SP_RST, resetSp_q);
        rst_b = 1'b1;
        testEnable();
        testTrip();
        testVote();
        testParams();
        finishTest();
    end
endmodule
`default_nettype wire
